/* core/lin_capable_fifo_uart.sv */
// fifo uart with break/sync, parity, bit-error abort and loopback
`timescale 1ns/1ps
`default_nettype none
`include "euart_defs.svh"

// How it works
// - separate fifteen-byte transmit and receive queues
// - sixteen-bit divisor clocked from system clock
// - bit time equals divisor plus one
// - enable bit gates sending of queued bytes and receiving; break is sent without it
// - stop bit control picks two or one
// - word length code selects five to eight
// - break drives low, then optional sync byte
// - break length thirteen to sixteen bit times
// - break bit busy, self clears, raises interrupt
// - queued bytes wait until sync sent
// - parity generated, checked, error per byte
// - stick parity sends constant one
// - receive active from start to stop
// - sticky bit error on tx/rx mismatch
// - tx abort on bit error option
// - rx abort on bit error option
// - loopback routes tx into rx
// - flush bit clears queues, self clears
// - queue byte counts readable
// - rx interrupt when count above threshold
// - rx threshold all ones flushes rx
// - tx interrupt when count below threshold
// - tx threshold zero flushes tx
module lin_capable_fifo_uart
   import euart_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int DIVW = 16
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // serial lines
   input wire logic rxIn,
   output logic txOut,
   // interrupt requests
   output logic rxReadyIrq,
   output logic txRoomIrq,
   output logic breakIrq,
   output logic mismatchIrq
);

   // pointer advance with wrap at queue depth
   function automatic logic [`FIFO_AW-1:0] nextPtr(
      input logic [`FIFO_AW-1:0] p);
      nextPtr = (p == `FIFO_AW'(DEPTH - 1)) ? '0 : p + `FIFO_AW'(1);
   endfunction

   // parity of the low n bits, odd or even
   function automatic logic parityOf(input logic [7:0] d,
      input logic [3:0] n, input logic odd);
      logic acc;
      acc = odd;
      for (int i = 0; i < 8; i++)
         if (4'(i) < n)
            acc = acc ^ d[i];
      parityOf = acc;
   endfunction

   // configuration registers
   logic enable_ff, twoStop_ff, breakBusy_ff, oddPar_ff, parOn_ff;
   logic stickPar_ff;
   logic [1:0] wordLen_ff;
   logic bit_mismatch_flag_ff, abortTx_ff, abortRx_ff, loopback_ff, errIrqEn_ff;
   logic invert_ff, brkIrqEn_ff, brkDone_ff, syncAfter_ff;
   logic [1:0] low_pulse_len_ff;
   logic [3:0] rxThr_ff, txThr_ff;
   logic [DIVW-1:0] divisor_ff;
   logic [7:0] regRdata_ff;

   // queues
   logic [8:0] rxMem_ff [DEPTH];
   logic [7:0] txMem_ff [DEPTH];
   logic [`FIFO_AW-1:0] rxWp_ff, rxRp_ff, rxCnt_ff;
   logic [`FIFO_AW-1:0] txWp_ff, txRp_ff, txCnt_ff;

   // transmitter and receiver state
   txst_t txState_ff;
   receive_active_t rxState_ff;
   logic [DIVW-1:0] txTick_ff, rxTick_ff;
   logic [4:0] txBits_ff;
   logic [3:0] rxBits_ff;
   logic [7:0] txShift_ff, rxShift_ff;
   logic txLine_ff, txSync_ff, rxPerr_ff, rxActive_ff;
   logic rxMeta_ff, rxPin_ff;

   // address decode and access strobes
   wire wrLine = regWr && (regAddr == `ADR_LINE_CFG);
   wire wrExt = regWr && (regAddr == `ADR_EXT_CFG);
   wire wrLvl = regWr && (regAddr == `ADR_FIFO_LVL);
   wire wrData = regWr && (regAddr == `ADR_DATA);
   wire wrBrk = regWr && (regAddr == `ADR_BRK_CFG);
   wire rdData = regRd && (regAddr == `ADR_DATA);

   // flush sources per queue
   wire flushAll = wrExt && regWdata[`BIT_FLUSH];
   wire rxThrFlush = wrLvl && (regWdata[7:4] == `RX_THR_FLUSH);
   wire txThrFlush = wrLvl && (regWdata[3:0] == `TX_THR_FLUSH);

   // serial timing derived from the divisor
   wire [DIVW-1:0] halfBit = divisor_ff >> 1;
   wire txBitEnd = (txTick_ff == divisor_ff);
   wire rxBitEnd = (rxTick_ff == divisor_ff);
   wire txMid = (txTick_ff == halfBit);
   wire [3:0] dataBits = `WORD_BASE + {2'b00, wordLen_ff};
   wire [3:0] txBitsNow = txSync_ff ? 4'h8 : dataBits;
   wire [4:0] brkBits = `BREAK_BASE + {3'b000, low_pulse_len_ff};

   // receive source: internal loop or synchronised pin
   wire rxBit = loopback_ff ? txLine_ff : rxPin_ff;

   // bit error compares what is sent with what comes back
   wire errSet = (txState_ff != TX_IDLE) && txMid
      && (rxBit != txLine_ff);
   wire txAbort = errSet && abortTx_ff;
   wire rxAbort = errSet && abortRx_ff;
   wire txFlush = flushAll || txThrFlush || txAbort;
   wire rxFlush = flushAll || rxThrFlush || rxAbort;

   // queue movements
   wire txFull = (txCnt_ff == `FIFO_AW'(DEPTH));
   wire rxFull = (rxCnt_ff == `FIFO_AW'(DEPTH));
   wire txPush = wrData && !txFull && !txFlush;
   wire txStart = enable_ff && (txState_ff == TX_IDLE) && !breakBusy_ff
      && (txCnt_ff != '0) && !txFlush && !brkStart;
   wire txPop = txStart;
   wire rxDone = (rxState_ff == RX_STOP) && rxBitEnd;
   wire rxPush = rxDone && rxBit && !rxFull && !rxFlush;
   wire rxPop = rdData && (rxCnt_ff != '0) && !rxFlush;
   wire [8:0] rxHead = rxMem_ff[rxRp_ff];
   wire brkStart = wrLine && regWdata[`BIT_BREAK] && !breakBusy_ff;
   wire brkEnd = txSync_ff ? ((txState_ff == TX_STOP) && txBitEnd
      && txBits_ff != 5'h1f) : ((txState_ff == TX_BRK) && txBitEnd
      && (txBits_ff == brkBits - 5'h01) && !syncAfter_ff);

   // received parity check
   wire rxParBad = (rxBit != (stickPar_ff ? 1'b1
      : parityOf(rxShift_ff, dataBits, oddPar_ff)));

   // read multiplexer
   wire [7:0] lineRd = {enable_ff, twoStop_ff, wordLen_ff, breakBusy_ff,
      oddPar_ff, rxHead[8] && (rxCnt_ff != '0), stickPar_ff};
   wire [7:0] extRd = {rxActive_ff, bit_mismatch_flag_ff, abortTx_ff, abortRx_ff,
      loopback_ff, errIrqEn_ff, 1'b0, invert_ff};
   wire [7:0] brkRd = {brkIrqEn_ff, 3'b000, brkDone_ff, syncAfter_ff,
      low_pulse_len_ff};
   wire [7:0] rdMux =
      (regAddr == `ADR_LINE_CFG) ? lineRd :
      (regAddr == `ADR_EXT_CFG) ? extRd :
      (regAddr == `ADR_FIFO_LVL) ? {rxCnt_ff, txCnt_ff} :
      (regAddr == `ADR_DATA) ? rxHead[7:0] :
      (regAddr == `ADR_BAUD_LO) ? divisor_ff[7:0] :
      (regAddr == `ADR_BAUD_HI) ? divisor_ff[15:8] :
      (regAddr == `ADR_BRK_CFG) ? brkRd : `REG_RESET;

   // outputs
   assign regRdata = regRdata_ff;
   assign txOut = txLine_ff ^ invert_ff;
   assign rxReadyIrq = (rxCnt_ff > rxThr_ff);
   assign txRoomIrq = (txCnt_ff < txThr_ff);
   assign breakIrq = brkDone_ff && brkIrqEn_ff;
   assign mismatchIrq = bit_mismatch_flag_ff && errIrqEn_ff;

   // pin synchroniser
   always_ff @(posedge clk)
   begin
      rxMeta_ff <= rxIn;
      rxPin_ff <= rxMeta_ff;
   end

   // read data register, valid the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!resetn)
         regRdata_ff <= `REG_RESET;
      else
         regRdata_ff <= regRd ? rdMux : `REG_RESET;
   end

   // software configuration, flags with set winning over clear
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         {enable_ff, twoStop_ff, wordLen_ff, oddPar_ff} <= '0;
         {parOn_ff, stickPar_ff, breakBusy_ff, bit_mismatch_flag_ff} <= '0;
         {abortTx_ff, abortRx_ff, loopback_ff, errIrqEn_ff} <= '0;
         {invert_ff, brkIrqEn_ff, brkDone_ff, syncAfter_ff} <= '0;
         low_pulse_len_ff <= '0;
         rxThr_ff <= '0;
         txThr_ff <= '0;
         divisor_ff <= '0;
      end
      else
      begin
         if (wrLine)
         begin
            enable_ff <= regWdata[`BIT_EN];
            twoStop_ff <= regWdata[`BIT_S2];
            wordLen_ff <= regWdata[5:4];
            oddPar_ff <= regWdata[`BIT_OD];
            parOn_ff <= regWdata[`BIT_PC];
            stickPar_ff <= regWdata[`BIT_PF];
         end
         if (brkStart)
            breakBusy_ff <= 1'b1;
         else if (brkEnd || txFlush)
            breakBusy_ff <= 1'b0;
         if (brkEnd)
            brkDone_ff <= 1'b1;
         else if (wrBrk && !regWdata[`BIT_BRKF])
            brkDone_ff <= 1'b0;
         if (errSet)
            bit_mismatch_flag_ff <= 1'b1;
         else if (wrExt && !regWdata[`BIT_ERRF])
            bit_mismatch_flag_ff <= 1'b0;
         if (wrExt)
         begin
            abortTx_ff <= regWdata[`BIT_ABTX];
            abortRx_ff <= regWdata[`BIT_ABRX];
            loopback_ff <= regWdata[`BIT_LBK];
            errIrqEn_ff <= regWdata[`BIT_ERRIE];
            invert_ff <= regWdata[`BIT_INV];
         end
         if (wrBrk)
         begin
            brkIrqEn_ff <= regWdata[`BIT_BRKIE];
            syncAfter_ff <= regWdata[`BIT_BSYNC];
            low_pulse_len_ff <= regWdata[1:0];
         end
         if (wrLvl && !rxThrFlush)
            rxThr_ff <= regWdata[7:4];
         if (wrLvl && !txThrFlush)
            txThr_ff <= regWdata[3:0];
         if (regWr && (regAddr == `ADR_BAUD_LO))
            divisor_ff[7:0] <= regWdata;
         if (regWr && (regAddr == `ADR_BAUD_HI))
            divisor_ff[15:8] <= regWdata;
      end
   end

   // transmit queue storage and pointers
   always_ff @(posedge clk)
   begin
      if (txPush)
         txMem_ff[txWp_ff] <= regWdata;
      if (!resetn || txFlush)
      begin
         txWp_ff <= '0;
         txRp_ff <= '0;
         txCnt_ff <= '0;
      end
      else
      begin
         if (txPush)
            txWp_ff <= nextPtr(txWp_ff);
         if (txPop)
            txRp_ff <= nextPtr(txRp_ff);
         txCnt_ff <= txCnt_ff + `FIFO_AW'(txPush) - `FIFO_AW'(txPop);
      end
   end

   // receive queue storage and pointers, parity flag kept per byte
   always_ff @(posedge clk)
   begin
      if (rxPush)
         rxMem_ff[rxWp_ff] <= {rxPerr_ff, rxShift_ff};
      if (!resetn || rxFlush)
      begin
         rxWp_ff <= '0;
         rxRp_ff <= '0;
         rxCnt_ff <= '0;
      end
      else
      begin
         if (rxPush)
            rxWp_ff <= nextPtr(rxWp_ff);
         if (rxPop)
            rxRp_ff <= nextPtr(rxRp_ff);
         rxCnt_ff <= rxCnt_ff + `FIFO_AW'(rxPush) - `FIFO_AW'(rxPop);
      end
   end

   // transmitter: break, sync byte and normal frames
   always_ff @(posedge clk)
   begin
      if (!resetn || txFlush)
      begin
         txState_ff <= TX_IDLE;
         txLine_ff <= 1'b1;
         txTick_ff <= '0;
         txBits_ff <= '0;
         txShift_ff <= '0;
         txSync_ff <= 1'b0;
      end
      else
      begin
         txTick_ff <= (txState_ff == TX_IDLE || txBitEnd) ? '0
            : txTick_ff + DIVW'(1);
         case (txState_ff)
            TX_IDLE:
            begin
               txLine_ff <= 1'b1;
               txBits_ff <= '0;
               if (brkStart || breakBusy_ff)
               begin
                  txState_ff <= TX_BRK;
                  txLine_ff <= 1'b0;
               end
               else if (txStart)
               begin
                  txState_ff <= TX_START;
                  txShift_ff <= txMem_ff[txRp_ff];
                  txLine_ff <= 1'b0;
               end
            end
            TX_BRK:
               if (txBitEnd)
               begin
                  txBits_ff <= txBits_ff + 5'h01;
                  if (txBits_ff == brkBits - 5'h01)
                  begin
                     txBits_ff <= '0;
                     if (syncAfter_ff)
                     begin
                        txState_ff <= TX_STOP; // one bit high mark
                        txLine_ff <= 1'b1;
                        txShift_ff <= `SYNC_BYTE;
                        txSync_ff <= 1'b1;
                        txBits_ff <= 5'h1f;
                     end
                     else
                     begin
                        txState_ff <= TX_IDLE;
                        txLine_ff <= 1'b1;
                     end
                  end
               end
            TX_START:
               if (txBitEnd)
               begin
                  txState_ff <= TX_DATA;
                  txLine_ff <= txShift_ff[0];
                  txBits_ff <= 5'h01;
               end
            TX_DATA:
               if (txBitEnd)
               begin
                  if (txBits_ff[3:0] == txBitsNow)
                  begin
                     txBits_ff <= '0;
                     if (parOn_ff && !txSync_ff)
                     begin
                        txState_ff <= TX_PAR;
                        txLine_ff <= stickPar_ff ? 1'b1
                           : parityOf(txShift_ff, dataBits, oddPar_ff);
                     end
                     else
                     begin
                        txState_ff <= TX_STOP;
                        txLine_ff <= 1'b1;
                     end
                  end
                  else
                  begin
                     txLine_ff <= txShift_ff[txBits_ff[2:0]];
                     txBits_ff <= txBits_ff + 5'h01;
                  end
               end
            TX_PAR:
               if (txBitEnd)
               begin
                  txState_ff <= TX_STOP;
                  txLine_ff <= 1'b1;
               end
            TX_STOP:
               if (txBitEnd)
               begin
                  if (txBits_ff == 5'h1f)
                  begin
                     txState_ff <= TX_START; // sync frame after mark
                     txLine_ff <= 1'b0;
                  end
                  else if (twoStop_ff && !txSync_ff
                     && txBits_ff == '0)
                     txBits_ff <= 5'h01;
                  else
                  begin
                     txState_ff <= TX_IDLE;
                     txSync_ff <= 1'b0;
                  end
               end
            default:
               txState_ff <= TX_IDLE;
         endcase
      end
   end

   // receiver: start detect, mid-bit sampling, parity and stop
   always_ff @(posedge clk)
   begin
      if (!resetn || rxFlush)
      begin
         rxState_ff <= RX_IDLE;
         rxTick_ff <= '0;
         rxBits_ff <= '0;
         rxShift_ff <= '0;
         rxPerr_ff <= 1'b0;
         rxActive_ff <= 1'b0;
      end
      else
      begin
         rxTick_ff <= (rxState_ff == RX_IDLE || rxBitEnd) ? '0
            : rxTick_ff + DIVW'(1);
         case (rxState_ff)
            RX_IDLE:
               if (enable_ff && !rxBit)
               begin
                  rxState_ff <= RX_START;
                  rxActive_ff <= 1'b1;
               end
            RX_START:
               if (rxTick_ff == halfBit)
               begin
                  rxTick_ff <= '0;
                  rxBits_ff <= '0;
                  rxShift_ff <= '0;
                  rxPerr_ff <= 1'b0;
                  rxState_ff <= rxBit ? RX_IDLE : RX_DATA;
                  rxActive_ff <= !rxBit;
               end
            RX_DATA:
               if (rxBitEnd)
               begin
                  rxShift_ff[rxBits_ff[2:0]] <= rxBit;
                  rxBits_ff <= rxBits_ff + 4'h1;
                  if (rxBits_ff + 4'h1 == dataBits)
                     rxState_ff <= parOn_ff ? RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (rxBitEnd)
               begin
                  rxPerr_ff <= rxParBad;
                  rxState_ff <= RX_STOP;
               end
            RX_STOP:
               if (rxBitEnd)
               begin
                  rxState_ff <= RX_IDLE;
                  rxActive_ff <= 1'b0;
               end
            default:
               rxState_ff <= RX_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

/* core/euart_defs.svh */
// register map, field positions and fixed counts of the serial unit
`ifndef EUART_DEFS_SVH
`define EUART_DEFS_SVH
`define ADR_LINE_CFG 8'hb1
`define ADR_EXT_CFG 8'hb2
`define ADR_FIFO_LVL 8'hb3
`define ADR_DATA 8'hb5
`define ADR_BAUD_LO 8'hb6
`define ADR_BAUD_HI 8'hb7
`define ADR_BRK_CFG 8'hc1
`define REG_RESET 8'h00
`define BIT_EN 7
`define BIT_S2 6
`define BIT_BREAK 3
`define BIT_OD 2
`define BIT_PC 1
`define BIT_PF 0
`define BIT_RXACT 7
`define BIT_ERRF 6
`define BIT_ABTX 5
`define BIT_ABRX 4
`define BIT_LBK 3
`define BIT_ERRIE 2
`define BIT_FLUSH 1
`define BIT_INV 0
`define BIT_BRKIE 7
`define BIT_BRKF 3
`define BIT_BSYNC 2
`define RX_THR_FLUSH 4'hf
`define TX_THR_FLUSH 4'h0
`define WORD_BASE 4'h5
`define BREAK_BASE 5'h0d
`define SYNC_BYTE 8'h55
`define FIFO_DEPTH 15
`define FIFO_AW 4
`endif

/* core/euart_pkg.sv */
// state types of the serial unit
`default_nettype none
package euart_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_BRK, TX_START, TX_DATA, TX_PAR,
      TX_STOP} txst_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
      RX_STOP} receive_active_t;
endpackage
`default_nettype wire

/* testbench/lin_capable_fifo_uart_checker.sv */
// checker for the fifo uart register port and serial pins
`timescale 1ns/1ps
`default_nettype none
module lin_capable_fifo_uart_checker #(
   parameter int DEPTH = 15,
   parameter int DIVW = 16
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   // serial lines
   input wire logic rxIn,
   input wire logic txOut,
   // interrupt requests
   input wire logic rxReadyIrq,
   input wire logic txRoomIrq,
   input wire logic breakIrq,
   input wire logic mismatchIrq
);
   logic [DIVW-1:0] div_ff;
   int lowLen_ff;
   int bitLen;
   logic clean_ff;
   logic wrExt;
   logic wrBrk;
   // writes that may clear sticky flags
   assign wrExt = regWr && regAddr == 8'hb2;
   assign wrBrk = regWr && regAddr == 8'hc1;
   assign bitLen = int'(div_ff) + 1;
   // divisor shadow, low run length, no write during the run
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         div_ff <= '0;
         lowLen_ff <= 0;
         clean_ff <= 1'b0;
      end
      else
      begin
         if (regWr && regAddr == 8'hb6)
            div_ff[7:0] <= regWdata;
         if (regWr && regAddr == 8'hb7)
            div_ff[DIVW-1:8] <= regWdata[DIVW-9:0];
         lowLen_ff <= txOut ? 0 : lowLen_ff + 1;
         clean_ff <= !regWr && (clean_ff || txOut);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_RD_IDLE: assert property (
      regRdata != 8'h00 |-> $past(regRd))
      else $error("read data outside a read cycle");
   AST_FLUSH_READS_ZERO: assert property (
      regRd && regAddr == 8'hb2 |=> !regRdata[1])
      else $error("flush bit read back as one");
   AST_RX_FLUSH_IRQ: assert property (
      regWr && regAddr == 8'hb3 && regWdata[7:4] == 4'hf |=> !rxReadyIrq)
      else $error("rx ready after rx flush");
   AST_RX_FLUSH_LEVEL: assert property (
      regWr && regAddr == 8'hb3 && regWdata[7:4] == 4'hf ##2
      regRd && regAddr == 8'hb3 |=> regRdata[7:4] == 4'h0)
      else $error("rx level not zero after rx flush");
   AST_TX_FLUSH_LEVEL: assert property (
      regWr && regAddr == 8'hb3 && regWdata[3:0] == 4'h0 ##2
      regRd && regAddr == 8'hb3 |=> regRdata[3:0] == 4'h0)
      else $error("tx level not zero after tx flush");
   AST_BIT_TIME: assert property (
      $rose(txOut) && clean_ff |-> lowLen_ff % bitLen == 0)
      else $error("low run not a whole number of bit times");
   AST_MISMATCH_STICKY: assert property (
      $fell(mismatchIrq) |-> $past(wrExt))
      else $error("bit error flag dropped without a write");
   AST_BREAK_STICKY: assert property (
      $fell(breakIrq) |-> $past(wrBrk))
      else $error("break done dropped without a write");

   COV_BREAK: cover property ($rose(breakIrq));
   COV_MISMATCH: cover property ($rose(mismatchIrq));
   COV_RX_READY: cover property ($rose(rxReadyIrq));
endmodule

bind lin_capable_fifo_uart lin_capable_fifo_uart_checker #(
   .DEPTH(DEPTH), .DIVW(DIVW)) lin_capable_fifo_uart_checker_i (
   .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIn(rxIn),
   .txOut(txOut), .rxReadyIrq(rxReadyIrq), .txRoomIrq(txRoomIrq),
   .breakIrq(breakIrq), .mismatchIrq(mismatchIrq));
`default_nettype wire

/* testbench/serial_peer.sv */
// remote serial node: sends frames to the unit, decodes what it sends
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   // clock
   input wire logic clk,
   // serial lines
   input wire logic lineIn,
   output logic lineOut,
   // frame setup
   input wire logic [7:0] bitLen,
   input wire logic [3:0] nBits,
   input wire logic listen,
   input wire logic stuck
);
   logic drive = 1'b1;
   logic [15:0] rxVal;
   logic [8:0] v;
   time t0;
   int k, j;
   event got;
   // line pulled high when released, held low when stuck
   assign lineOut = drive & ~stuck;
   // start, bits lsb first, stop and idle
   task send(input logic [8:0] bits, input int n);
      drive <= 1'b0;
      repeat (bitLen) @(posedge clk);
      for (k = 0; k < n; k++)
      begin
         drive <= bits[k];
         repeat (bitLen) @(posedge clk);
      end
      drive <= 1'b1;
      repeat (2 * bitLen) @(posedge clk);
   endtask
   // mid-bit decode; a low stop means a break, measured in bit times
   always
   begin
      @(negedge lineIn);
      if (listen)
      begin
         t0 = $time;
         v = 9'h0;
         repeat (bitLen / 2) @(posedge clk);
         for (j = 0; j < nBits; j++)
         begin
            repeat (bitLen) @(posedge clk);
            v[j] = lineIn;
         end
         repeat (bitLen) @(posedge clk);
         if (lineIn)
            rxVal = {7'h0, v};
         else
         begin
            @(posedge lineIn);
            rxVal = {8'hbb, 8'(($time - t0) / (40 * bitLen))};
         end
         ->got;
      end
   end
endmodule
`default_nettype wire

/* testbench/lin_capable_fifo_uart_bench.sv */
// self-checking bench of the fifo uart with a remote serial node
`timescale 1ns/1ps
`default_nettype none
module lin_capable_fifo_uart_bench;
   localparam int LIMIT = 60000;
   logic clk, resetn, regWr, regRd, rdWas, listen, stuck, p;
   logic [7:0] regAddr, regWdata, regRdata, d, code, bitLen;
   logic rxIn, txOut, rxReadyIrq, txRoomIrq, breakIrq, mismatchIrq;
   logic [3:0] nBits;
   logic [15:0] note;
   logic [7:0] rb[3];
   logic [15:0] rdQ[$];
   logic [15:0] serQ[$];
   string nmQ[$];
   int fails, n_checks, cyc, i, w;
   logic [7:0] adr[7] = '{8'hb1, 8'hb2, 8'hb3, 8'hb6, 8'hb7, 8'hc1, 8'h00};
   logic [7:0] fmt[7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h02, 8'h06, 8'h03};

   lin_capable_fifo_uart lin_capable_fifo_uart_i (
      .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxIn(rxIn),
      .txOut(txOut), .rxReadyIrq(rxReadyIrq), .txRoomIrq(txRoomIrq),
      .breakIrq(breakIrq), .mismatchIrq(mismatchIrq));
   serial_peer serial_peer_i (.clk(clk), .lineIn(txOut), .lineOut(rxIn),
      .bitLen(bitLen), .nBits(nBits), .listen(listen), .stuck(stuck));

   // clock
   always #20 clk = ~clk;

   task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_ser(input logic [15:0] e, input logic [15:0] g);
      chk_reg("serial high", e[15:8], g[15:8]);
      chk_reg("serial low", e[7:0], g[7:0]);
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one write cycle, then a gap cycle
   task wr(input logic [7:0] a, input logic [7:0] v);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   // one read cycle; expected value and mask noted for the monitor
   task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
      input string nm);
      rdQ.push_back({m, e});
      nmQ.push_back(nm);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
   endtask
   task drain;
      int k;
      for (k = 0; k < 5000 && serQ.size() > 0; k++)
         @(posedge clk);
      repeat (3 * bitLen) @(posedge clk);
   endtask

   // read data checked in the cycle after the strobe; hang guard
   always @(posedge clk)
   begin
      if (rdWas)
      begin
         note = rdQ.pop_front();
         chk_reg(nmQ.pop_front(), note[7:0], regRdata & note[15:8]);
      end
      rdWas <= regRd;
      cyc++;
      if (cyc == LIMIT)
      begin
         fails++;
         tally_and_finish();
      end
   end
   // serial frames seen by the peer against the oldest note
   always @(serial_peer_i.got)
      chk_ser(serQ.pop_front(), serial_peer_i.rxVal);

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      {regAddr, regWdata, regWr, regRd, rdWas, stuck} = '0;
      {fails, n_checks, cyc} = '0;
      listen = 1'b1;
      nBits = 4'h8;
      d = 8'($urandom(32'hdfe3));
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      foreach (adr[k])
         rd(adr[k], 8'h00, 8'hff, "reset value");
      d = 8'(3 + $urandom % 4);
      bitLen = d + 8'h1;
      wr(8'hb6, d);
      wr(8'hb7, 8'h00);
      rd(8'hb6, d, 8'hff, "divisor");
      // word lengths, two stops, even, odd and stuck parity
      for (i = 0; i < 7; i++)
      begin
         w = (i < 4) ? i : 3;
         nBits = 4'((i < 3) ? 5 + w : 9);
         wr(8'hb1, 8'h80 | 8'(w << 4) | fmt[i]);
         repeat (2)
         begin
            d = 8'($urandom);
            p = (i == 4) ? ^d : (i == 5) ? ~^d : (i > 2);
            serQ.push_back({7'h0, p, d & (8'hff >> (3 - w))});
            wr(8'hb5, d);
         end
         drain();
      end
      nBits = 4'h8;
      listen = 1'b0;
      wr(8'hb2, 8'h01);
      chk_reg("txOut", 8'h00, {7'h0, txOut});
      wr(8'hb2, 8'h00);
      chk_reg("txOut", 8'h01, {7'h0, txOut});
      listen = 1'b1;
      // fill past depth while disabled, thresholds, flushes
      wr(8'hb1, 8'h00);
      repeat (16) wr(8'hb5, 8'($urandom));
      rd(8'hb3, 8'h0f, 8'h0f, "tx level");
      wr(8'hb3, 8'h0f);
      chk_reg("txRoomIrq", 8'h00, {7'h0, txRoomIrq});
      wr(8'hb3, 8'h00);
      chk_reg("txRoomIrq", 8'h01, {7'h0, txRoomIrq});
      rd(8'hb3, 8'h00, 8'h0f, "tx flush");
      repeat (3) wr(8'hb5, 8'h5a);
      wr(8'hb2, 8'h02);
      rd(8'hb3, 8'h00, 8'hff, "flush");
      // receive, rx threshold, parity error of head byte
      wr(8'hb1, 8'hb0);
      foreach (rb[k])
      begin
         rb[k] = 8'($urandom);
         serial_peer_i.send({1'b0, rb[k]}, 8);
      end
      rd(8'hb3, 8'h30, 8'hf0, "rx level");
      wr(8'hb3, 8'h21);
      chk_reg("rxReadyIrq", 8'h01, {7'h0, rxReadyIrq});
      wr(8'hb3, 8'h31);
      chk_reg("rxReadyIrq", 8'h00, {7'h0, rxReadyIrq});
      rd(8'hb5, rb[0], 8'hff, "rx data");
      wr(8'hb1, 8'hb2);
      d = 8'($urandom);
      serial_peer_i.send({~^d, d}, 9);
      rd(8'hb1, 8'h00, 8'h02, "parity ok");
      rd(8'hb5, rb[1], 8'hff, "rx data");
      rd(8'hb5, rb[2], 8'hff, "rx data");
      rd(8'hb1, 8'h02, 8'h02, "parity bad");
      wr(8'hb3, 8'hf1);
      rd(8'hb3, 8'h00, 8'hf0, "rx flush");
      // break, sync, then the byte held back
      wr(8'hb1, 8'hb0);
      code = 8'($urandom % 4);
      wr(8'hc1, 8'h84 | code);
      d = 8'($urandom);
      serQ.push_back({8'hbb, 8'd13 + code});
      serQ.push_back(16'h0055);
      serQ.push_back({8'h00, d});
      wr(8'hb1, 8'hb8);
      rd(8'hb1, 8'h08, 8'h08, "break busy");
      wr(8'hb5, d);
      drain();
      chk_reg("breakIrq", 8'h01, {7'h0, breakIrq});
      rd(8'hb1, 8'h00, 8'h08, "break done");
      wr(8'hc1, 8'h00);
      // loopback
      listen = 1'b0;
      wr(8'hb2, 8'h08);
      d = 8'($urandom);
      repeat (2) wr(8'hb5, d);
      repeat (3 * bitLen) @(posedge clk);
      rd(8'hb2, 8'h80, 8'h80, "rx active");
      repeat (21 * bitLen) @(posedge clk);
      rd(8'hb5, d, 8'hff, "loopback");
      // receive pin stuck low: bit error aborts both directions
      wr(8'hb2, 8'h34);
      stuck <= 1'b1;
      wr(8'hb5, 8'hff);
      wr(8'hb5, 8'hff);
      repeat (4 * bitLen) @(posedge clk);
      chk_reg("mismatchIrq", 8'h01, {7'h0, mismatchIrq});
      rd(8'hb3, 8'h00, 8'hff, "abort");
      stuck <= 1'b0;
      repeat (14 * bitLen) @(posedge clk);
      wr(8'hb3, 8'hf1);
      wr(8'hb2, 8'h44);
      chk_reg("mismatchIrq", 8'h01, {7'h0, mismatchIrq});
      wr(8'hb2, 8'h04);
      chk_reg("mismatchIrq", 8'h00, {7'h0, mismatchIrq});
      listen = 1'b1;
      chk_reg("pending", 8'h00, 8'(serQ.size() + rdQ.size()));
      tally_and_finish();
   end
endmodule
`default_nettype wire
